/* File: adtc_map.svh */
/*
 * register map, field positions, reset values and timing counts of the
 * converter trigger and control block.
 * assumes 8-bit registers, one per aligned 32-bit wishbone word.
 */
// Summary of operation
// [RQ1] discharge capacitor array before every sample
// [RQ2] compare event with mode 1011 sets go
// [RQ3] every compare event clears the timer counter; the code clears it only for compare mode 1011
// [RQ4] converter off: trigger ignored, timer still cleared
// [RQ5] software picks channel and acquisition beforehand
// [RQ6] unimplemented bits read zero, ignore writes
// [RQ7] 28-pin: parallel port bits unimplemented, kept clear
// [RQ8] completion clears go, sets flag, resumes sampling
// [RQ9] acquisition 2..20 periods; zero means manual
// [RQ10] conversion lasts exactly eleven bit periods
// [RQ11] abort keeps result, waits two periods first
// [RQ12] flag and enable raise high/low request
`ifndef ADTC_MAP_SVH
`define ADTC_MAP_SVH
// byte addresses
`define ADTC_OFF_FLAGS    8'h00
`define ADTC_OFF_ENABLES  8'h04
`define ADTC_OFF_PRIORITY 8'h08
`define ADTC_OFF_RES_HI   8'h0C
`define ADTC_OFF_RES_LO   8'h10
`define ADTC_OFF_CTRL0    8'h14
`define ADTC_OFF_CTRL1    8'h18
`define ADTC_OFF_CTRL2    8'h1C
// field positions
`define ADTC_BIT_PARPORT  7
`define ADTC_BIT_CONV     6
`define ADTC_BIT_EN       0
`define ADTC_BIT_GO       1
`define ADTC_BIT_JUSTIFY  7
// implemented-bit masks and the reset byte
`define ADTC_MASK_CTRL0   8'h3F
`define ADTC_MASK_CTRL1   8'h3F
`define ADTC_MASK_CTRL2   8'hBF
`define ADTC_MASK_28PIN   8'h7F
`define ADTC_MASK_ALL     8'hFF
`define ADTC_RESET_BYTE   8'h00
// compare mode in which a special event counts as a trigger
`define ADTC_TRIG_MODE    4'hB
// timing, in bit periods, and the sar start code
`define ADTC_SETTLE_TAD   5'h02
`define ADTC_CONV_TAD     5'h0B
`define ADTC_LAST_BIT_TAD 5'h0A
`define ADTC_SAR_START    10'h200
`endif

/* File: adtc_pkg.sv */
/*
 * types of the converter trigger and control block.
 * assumes adtc_map.svh is included where offsets are needed.
 */
package adtc_pkg;
    // sequencer phases
    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,  // post-cycle wait, array discharging
        ST_TRACK  = 2'b01,  // sampling selected channel
        ST_ACQ    = 2'b10,  // timed acquisition after go
        ST_CONV   = 2'b11   // successive approximation
    } adtc_state_e;

    // signals toward the analog front end
    typedef struct packed {
        logic       discharge;  // capacitor array reset
        logic       sample;     // sample switch closed
        logic       convert;    // comparator in use
        logic [9:0] code;       // dac trial code
        logic [3:0] channel;    // analog mux select
    } adtc_afe_s;
endpackage

/* File: adtc_top.sv */
/*
 * converter trigger and control: wishbone register file, compare-event
 * trigger, acquisition/conversion sequencer and interrupt request.
 * assumes a synchronous compare event pulse, a comparator bit from the
 * analog core valid within one bit period, and a classic wishbone master.
 */
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "adtc_map.svh"
module adtc_top
    import adtc_pkg::*;
#(
    parameter bit         PIN28       = 1'b1,  // smaller package variant
    parameter logic [7:0] RC_TAD_CLKS = 8'h40  // internal rc period, clocks
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // compare unit and its timer
    input  wire logic [3:0]  compare_mode_i,
    input  wire logic        special_event_i,
    output logic             timer_clear_o,
    // analog core
    input  wire logic        cmp_i,
    output adtc_afe_s        afe_o,
    output logic [1:0]       reference_select_o,
    output logic [3:0]       pin_analog_config_o,
    // interrupt requests
    output logic             irq_high_o,
    output logic             irq_low_o
);
    // clocks per bit period for a clock select code
    function automatic logic [7:0] tad_clocks(input logic [2:0] cs);
        case (cs)
            3'h0:    tad_clocks = 8'h02;
            3'h4:    tad_clocks = 8'h04;
            3'h1:    tad_clocks = 8'h08;
            3'h5:    tad_clocks = 8'h10;
            3'h2:    tad_clocks = 8'h20;
            3'h6:    tad_clocks = 8'h40;
            default: tad_clocks = RC_TAD_CLKS;
        endcase
    endfunction

    // automatic acquisition length in bit periods, zero is manual
    function automatic logic [4:0] acq_tads(input logic [2:0] sel);
        case (sel)
            3'h1:    acq_tads = 5'h02;
            3'h2:    acq_tads = 5'h04;
            3'h3:    acq_tads = 5'h06;
            3'h4:    acq_tads = 5'h08;
            3'h5:    acq_tads = 5'h0C;
            3'h6:    acq_tads = 5'h10;
            3'h7:    acq_tads = 5'h14;
            default: acq_tads = 5'h00;
        endcase
    endfunction

    localparam logic [7:0] PARMASK = PIN28 ? `ADTC_MASK_28PIN
                                           : `ADTC_MASK_ALL;

    adtc_state_e state_q, state_d;  // sequencer phase
    logic [7:0]  flags_q;           // peripheral flags
    logic [7:0]  enables_q;         // peripheral enables
    logic [7:0]  prio_q;            // peripheral priorities
    logic [7:0]  res_hi_q;          // result high byte
    logic [7:0]  res_lo_q;          // result low byte
    logic [3:0]  channel_q;         // channel_select
    logic        enable_q;          // converter_enable
    logic        go_q;              // go/done
    logic [5:0]  ctrl1_q;           // reference and pin config
    logic [7:0]  ctrl2_q;           // justify, acq time, clock select
    logic [7:0]  tad_len_q;         // bit period latched while tracking
    logic [7:0]  cyc_q;             // clocks within current period
    logic [4:0]  tad_q;             // periods within current phase
    logic [9:0]  sar_q;             // approximation register
    logic [7:0]  rd_data;           // read mux
    logic        req, wr_w, wr0;
    logic        tick, done_w, trig_hit, start_w, abort_w;
    logic [9:0]  trial;

    // bus decode; a write lands on the edge where ack is high
    assign req    = wb_cyc_i && wb_stb_i;
    assign wr_w   = req && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign wr0    = wr_w && (wb_adr_i == `ADTC_OFF_CTRL0);
    assign tick   = (cyc_q == tad_len_q - 8'h01);
    assign done_w = (state_q == ST_CONV) && go_q && tick &&
                    (tad_q == `ADTC_LAST_BIT_TAD);              // [RQ10]
    assign trig_hit = special_event_i &&
                      (compare_mode_i == `ADTC_TRIG_MODE);
    // go accepted only while tracking with the converter already on; a
    // write that sets go but clears enable must not start a cycle
    assign start_w = enable_q && !go_q && (state_q == ST_TRACK) &&
                     (trig_hit ||                               // [RQ2]
                      (wr0 && wb_dat_i[`ADTC_BIT_GO] &&
                       wb_dat_i[`ADTC_BIT_EN]));                // [RQ4]
    // clearing go, or switching the converter off, aborts
    assign abort_w = go_q && !done_w && wr0 &&
                     (!wb_dat_i[`ADTC_BIT_GO] ||
                      !wb_dat_i[`ADTC_BIT_EN]);                 // [RQ11]

    // single-cycle ack, dropped the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
            if (req && !wb_ack_o) begin
                wb_dat_o <= {24'h00_0000, rd_data};
            end
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        rd_data = `ADTC_RESET_BYTE;
        case (wb_adr_i)
            `ADTC_OFF_FLAGS:    rd_data = flags_q & PARMASK;    // [RQ7]
            `ADTC_OFF_ENABLES:  rd_data = enables_q & PARMASK;
            `ADTC_OFF_PRIORITY: rd_data = prio_q & PARMASK;
            `ADTC_OFF_RES_HI:   rd_data = res_hi_q;
            `ADTC_OFF_RES_LO:   rd_data = res_lo_q;
            `ADTC_OFF_CTRL0:    rd_data = {2'h0, channel_q, go_q,
                                           enable_q};           // [RQ6]
            `ADTC_OFF_CTRL1:    rd_data = {2'h0, ctrl1_q};
            `ADTC_OFF_CTRL2:    rd_data = ctrl2_q & `ADTC_MASK_CTRL2;
            default:            rd_data = `ADTC_RESET_BYTE;
        endcase
    end

    // interrupt registers; completion set wins over a software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q   <= `ADTC_RESET_BYTE;
            enables_q <= `ADTC_RESET_BYTE;
            prio_q    <= `ADTC_RESET_BYTE;
        end else begin
            if (wr_w && wb_adr_i == `ADTC_OFF_ENABLES) begin
                enables_q <= wb_dat_i[7:0] & PARMASK;           // [RQ7]
            end
            if (wr_w && wb_adr_i == `ADTC_OFF_PRIORITY) begin
                prio_q <= wb_dat_i[7:0] & PARMASK;
            end
            if (wr_w && wb_adr_i == `ADTC_OFF_FLAGS) begin
                flags_q <= wb_dat_i[7:0] & PARMASK;
            end
            if (done_w) begin
                flags_q[`ADTC_BIT_CONV] <= 1'b1;                // [RQ8]
            end
        end
    end

    // control registers; unimplemented bits are never stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_q <= 4'h0;
            enable_q  <= 1'b0;
            ctrl1_q   <= 6'h00;
            ctrl2_q   <= `ADTC_RESET_BYTE;
        end else begin
            if (wr0) begin
                channel_q <= wb_dat_i[5:2];                     // [RQ5]
                enable_q  <= wb_dat_i[`ADTC_BIT_EN];
            end
            if (wr_w && wb_adr_i == `ADTC_OFF_CTRL1) begin
                ctrl1_q <= wb_dat_i[5:0];                       // [RQ6]
            end
            if (wr_w && wb_adr_i == `ADTC_OFF_CTRL2) begin
                ctrl2_q <= wb_dat_i[7:0] & `ADTC_MASK_CTRL2;
            end
        end
    end

    // go/done: completion and abort clear it, a start sets it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            go_q <= 1'b0;
        end else if (done_w || abort_w) begin
            go_q <= 1'b0;                                       // [RQ8]
        end else if (start_w) begin
            go_q <= 1'b1;                                       // [RQ2]
        end
    end

    // timer clear follows every compare event in mode 1011, converter on or off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_clear_o <= 1'b0;
        end else begin
            timer_clear_o <= trig_hit;                          // [RQ3] [RQ4]
        end
    end

    // sequencer next phase
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_SETTLE: begin
                // two periods of discharge before sampling resumes
                if (tick && tad_q == `ADTC_SETTLE_TAD - 5'h01) begin
                    state_d = ST_TRACK;                         // [RQ1] [RQ11]
                end
            end
            ST_TRACK: begin
                if (go_q) begin
                    state_d = (acq_tads(ctrl2_q[5:3]) == 5'h00) ?
                              ST_CONV : ST_ACQ;                 // [RQ9]
                end
            end
            ST_ACQ: begin
                if (!go_q) begin
                    state_d = ST_SETTLE;
                end else if (tick &&
                        tad_q == acq_tads(ctrl2_q[5:3]) - 5'h01) begin
                    state_d = ST_CONV;                          // [RQ9]
                end
            end
            ST_CONV: begin
                // done clears go, so both abort and finish settle
                if (!go_q || done_w) begin
                    state_d = ST_SETTLE;                        // [RQ8] [RQ11]
                end
            end
            default: state_d = ST_SETTLE;
        endcase
    end

    // phase register, bit period length latched outside a cycle so a
    // mid-conversion clock change cannot stretch the conversion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q   <= ST_SETTLE;
            tad_len_q <= tad_clocks(3'h0);
        end else begin
            state_q <= state_d;
            if (state_q != ST_ACQ && state_q != ST_CONV) begin
                tad_len_q <= tad_clocks(ctrl2_q[2:0]);
            end
        end
    end

    // period counters restart at every phase change
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != state_d) begin
            cyc_q <= 8'h00;
            tad_q <= 5'h00;
        end else if (tick) begin
            cyc_q <= 8'h00;
            tad_q <= tad_q + 5'h01;
        end else begin
            cyc_q <= cyc_q + 8'h01;
        end
    end

    // successive approximation: one bit decided per period, the
    // eleventh period closes the conversion
    assign trial = `ADTC_SAR_START >> tad_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sar_q <= 10'h000;
        end else if (state_q != ST_CONV && state_d == ST_CONV) begin
            sar_q <= `ADTC_SAR_START;
        end else if (state_q == ST_CONV && tick &&
                     tad_q < `ADTC_LAST_BIT_TAD) begin
            sar_q <= (cmp_i ? sar_q : (sar_q & ~trial)) | (trial >> 1);
        end
    end

    // result registers; abort leaves the previous value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_hi_q <= `ADTC_RESET_BYTE;
            res_lo_q <= `ADTC_RESET_BYTE;
        end else if (done_w) begin
            if (ctrl2_q[`ADTC_BIT_JUSTIFY]) begin
                res_hi_q <= {6'h00, sar_q[9:8]};
                res_lo_q <= sar_q[7:0];
            end else begin
                res_hi_q <= sar_q[9:2];
                res_lo_q <= {sar_q[1:0], 6'h00};
            end
        end else begin
            if (wr_w && wb_adr_i == `ADTC_OFF_RES_HI) begin
                res_hi_q <= wb_dat_i[7:0];
            end
            if (wr_w && wb_adr_i == `ADTC_OFF_RES_LO) begin
                res_lo_q <= wb_dat_i[7:0];
            end
        end
    end

    // interrupt request steered by priority bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_high_o <= 1'b0;
            irq_low_o  <= 1'b0;
        end else begin
            irq_high_o <= flags_q[`ADTC_BIT_CONV] &&
                          enables_q[`ADTC_BIT_CONV] &&
                          prio_q[`ADTC_BIT_CONV];               // [RQ12]
            irq_low_o  <= flags_q[`ADTC_BIT_CONV] &&
                          enables_q[`ADTC_BIT_CONV] &&
                          !prio_q[`ADTC_BIT_CONV];
        end
    end

    // analog side, straight from state flops
    assign afe_o.discharge   = (state_q == ST_SETTLE);          // [RQ1]
    assign afe_o.sample      = (state_q == ST_TRACK) ||
                               (state_q == ST_ACQ);
    assign afe_o.convert     = (state_q == ST_CONV);
    assign afe_o.code        = sar_q;
    assign afe_o.channel     = channel_q;
    assign reference_select_o  = ctrl1_q[5:4];
    assign pin_analog_config_o = ctrl1_q[3:0];

    // helper: clocks spent in the conversion phase
    logic [11:0] conv_clks_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != ST_CONV) begin
            conv_clks_q <= 12'h000;
        end else begin
            conv_clks_q <= conv_clks_q + 12'h001;
        end
    end

    property p_discharge;
        @(posedge clk_i) disable iff (rst_i)
        $rose(afe_o.sample) |-> $past(afe_o.discharge);
    endproperty
    a_discharge: assert property (p_discharge) // [RQ1]
        else $error("sampling began without discharge");

    property p_trigger;
        @(posedge clk_i) disable iff (rst_i)
        (trig_hit && enable_q && !go_q && state_q == ST_TRACK)
            |=> go_q ##1 (state_q != ST_TRACK);
    endproperty
    a_trigger: assert property (p_trigger) // [RQ2]
        else $error("trigger did not start a cycle");

    property p_timer;
        @(posedge clk_i) disable iff (rst_i)
        trig_hit |=> timer_clear_o;
    endproperty
    a_timer: assert property (p_timer) // [RQ3]
        else $error("timer clear missing");

    property p_ignored;
        @(posedge clk_i) disable iff (rst_i)
        (trig_hit && !enable_q) |=> !go_q && timer_clear_o;
    endproperty
    a_ignored: assert property (p_ignored) // [RQ4]
        else $error("disabled converter reacted");

    property p_unimpl;
        @(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && wb_adr_i == `ADTC_OFF_CTRL0) |-> wb_dat_o[7:6] == 2'h0;
    endproperty
    a_unimpl: assert property (p_unimpl) // [RQ6]
        else $error("unimplemented bits read nonzero");

    property p_parport;
        @(posedge clk_i) disable iff (rst_i)
        PIN28 |-> !flags_q[`ADTC_BIT_PARPORT] &&
                  !enables_q[`ADTC_BIT_PARPORT];
    endproperty
    a_parport: assert property (p_parport) // [RQ7]
        else $error("parallel port bit set");

    property p_done;
        @(posedge clk_i) disable iff (rst_i)
        done_w |=> !go_q && flags_q[`ADTC_BIT_CONV] && afe_o.discharge;
    endproperty
    a_done: assert property (p_done) // [RQ8]
        else $error("completion effects missing");

    property p_manual;
        @(posedge clk_i) disable iff (rst_i)
        ($rose(go_q) && ctrl2_q[5:3] == 3'h0) |=> state_q == ST_CONV;
    endproperty
    a_manual: assert property (p_manual) // [RQ9]
        else $error("manual start not immediate");

    property p_convlen;
        @(posedge clk_i) disable iff (rst_i)
        done_w |-> conv_clks_q ==
            (12'(`ADTC_CONV_TAD) * 12'(tad_len_q)) - 12'h001;
    endproperty
    a_convlen: assert property (p_convlen) // [RQ10]
        else $error("conversion length wrong");

    property p_abort;
        @(posedge clk_i) disable iff (rst_i)
        (abort_w && state_q == ST_CONV) |=> !go_q ##1
            (state_q == ST_SETTLE && res_hi_q == $past(res_hi_q, 2));
    endproperty
    a_abort: assert property (p_abort) // [RQ11]
        else $error("abort mishandled");

    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        (flags_q[`ADTC_BIT_CONV] && enables_q[`ADTC_BIT_CONV])
            |=> (irq_high_o || irq_low_o) && !(irq_high_o && irq_low_o);
    endproperty
    a_irq: assert property (p_irq) // [RQ12]
        else $error("interrupt request missing");
endmodule

/* File: adtc_cmp_model.sv */
/* compare unit model: a timer whose period match fires the special event.
 * assumes the converter block pulses timer_clear_i after an event in mode 1011. */
`timescale 1ns/1ps
module adtc_cmp_model #(
    parameter logic [15:0] PERIOD = 16'h0010  // match value, clocks
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // bench control
    input  wire logic        arm_i,
    input  wire logic [3:0]  mode_i,
    // converter block side
    input  wire logic        timer_clear_i,
    output logic      [3:0]  compare_mode_o,
    output logic             special_event_o,
    output logic      [15:0] timer_o
);
    // mode field is static configuration from the bench
    assign compare_mode_o = mode_i;
    // timer wraps at the match, so a stale count never hides a missed clear
    always_ff @(posedge clk_i) begin
        if (rst_i || timer_clear_i || timer_o == PERIOD) begin
            timer_o <= 16'h0000;
        end else begin
            timer_o <= timer_o + 16'h0001;
        end
    end
    // one-cycle event on a match while armed
    always_ff @(posedge clk_i) begin
        special_event_o <= !rst_i && arm_i && (timer_o == PERIOD);
    end
endmodule

/* File: adc_trigger_and_control_tb.sv */
/* self-checking bench for the converter trigger and control block.
 * assumes a wishbone ack one cycle after the request and a 2-clock
 * bit period for clock code 000, 16 clocks for code 101. */
`timescale 1ns/1ps
`include "adtc_map.svh"
module adc_trigger_and_control_tb;
    import adtc_pkg::*;
    logic        clk_i = 1'b0;  // 250 MHz system clock
    logic        rst_i = 1'b1;  // synchronous reset
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, arm = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0, mode = 4'h0, cmode, pincfg;
    logic [31:0] wdat = 32'h0, rdat;
    logic        ack, sev, tclr, cmp, irqh, irql;
    logic [15:0] timer;
    logic [1:0]  refsel;
    logic [9:0]  target = 10'h2A5;  // analog input as a code
    adtc_afe_s   afe;
    int          errors = 0, cmp_count = 0;
    int          run_c = 0, run_d = 0, last_c = 0, last_d = 0;
    int          acq_n = 0;  // clocks from go write to conversion start

    adtc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .compare_mode_i(cmode), .special_event_i(sev),
        .timer_clear_o(tclr), .cmp_i(cmp), .afe_o(afe),
        .reference_select_o(refsel), .pin_analog_config_o(pincfg),
        .irq_high_o(irqh), .irq_low_o(irql));
    adtc_cmp_model i_cmp (.clk_i(clk_i), .rst_i(rst_i), .arm_i(arm),
        .mode_i(mode), .timer_clear_i(tclr), .compare_mode_o(cmode),
        .special_event_o(sev), .timer_o(timer));

    always #2 clk_i = ~clk_i;
    // comparator: high while the input is at or above the trial code
    assign cmp = (target >= afe.code);
    // lengths of the last convert and discharge runs, in clocks
    always @(posedge clk_i) begin
        if (afe.convert) run_c <= run_c + 1;
        else if (run_c != 0) begin last_c <= run_c; run_c <= 0; end
        if (afe.discharge) run_d <= run_d + 1;
        else if (run_d != 0) begin last_d <= run_d; run_d <= 0; end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one classic cycle; held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a;
        wdat <= {24'h0, d}; sel <= 4'h1;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 8'h00, q);
        check(q, {24'h0, e});
    endtask
    // arm the compare unit until one event fires, then see timer effects
    task automatic fire(input logic [3:0] m, input logic c);
        @(posedge clk_i);
        mode <= m; arm <= 1'b1;
        do @(posedge clk_i); while (sev !== 1'b1);
        arm <= 1'b0;
        @(posedge clk_i);
        check({31'h0, tclr}, {31'h0, c});
        @(posedge clk_i);
        check({16'h0, timer}, c ? 32'h0 : 32'h2);
    endtask
    // wait, bounded, for the sequencer to track again
    task automatic wait_track();
        int n;
        n = 0;
        do begin @(posedge clk_i); n++; end
        while (afe.sample !== 1'b1 && n < 3000);
        // one more edge so run lengths latched at the exit edge are seen
        @(posedge clk_i);
        check({31'h0, afe.sample}, 32'h1);
    endtask
    task automatic summarize();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a <= 32; a += 4) rd(a[7:0], 8'h00);
        wr(`ADTC_OFF_CTRL1, 8'hFF);
        rd(`ADTC_OFF_CTRL1, 8'h3F);
        check({28'h0, pincfg}, 32'hF);
        check({30'h0, refsel}, 32'h3);
        wr(`ADTC_OFF_CTRL2, 8'hFF);
        rd(`ADTC_OFF_CTRL2, 8'hBF);
        wr(`ADTC_OFF_CTRL0, 8'h3C);
        rd(`ADTC_OFF_CTRL0, 8'h3C);
        check({28'h0, afe.channel}, 32'hF);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        // channel 0 picked and manual acquisition set ahead of any event
        wr(`ADTC_OFF_CTRL0, 8'h00);
        wr(`ADTC_OFF_CTRL2, 8'h80);
        fire(4'hB, 1'b1);
        rd(`ADTC_OFF_CTRL0, 8'h00);
        fire(4'hA, 1'b0);
        wr(`ADTC_OFF_CTRL0, 8'h01);
        wait_track();
        fire(4'hB, 1'b1);
        wait_track();
        check(last_c, 32'd22);
        check(last_d, 32'd4);
        rd(`ADTC_OFF_CTRL0, 8'h01);
        rd(`ADTC_OFF_RES_HI, 8'h02);
        rd(`ADTC_OFF_RES_LO, 8'hA5);
        rd(`ADTC_OFF_FLAGS, 8'h40);
        // interrupt steering, then clearing the flag drops it
        wr(`ADTC_OFF_ENABLES, 8'hFF);
        rd(`ADTC_OFF_ENABLES, 8'h7F);
        check({30'h0, irqh, irql}, 32'h1);
        wr(`ADTC_OFF_PRIORITY, 8'h40);
        rd(`ADTC_OFF_PRIORITY, 8'h40);
        check({30'h0, irqh, irql}, 32'h2);
        wr(`ADTC_OFF_FLAGS, 8'h00);
        rd(`ADTC_OFF_FLAGS, 8'h00);
        check({30'h0, irqh, irql}, 32'h0);
        // slow bit period, software go, then abort mid-conversion
        target <= 10'h155;
        wr(`ADTC_OFF_CTRL2, 8'h85);
        wait_track();
        wr(`ADTC_OFF_CTRL0, 8'h03);
        rd(`ADTC_OFF_CTRL0, 8'h03);
        wr(`ADTC_OFF_CTRL0, 8'h01);
        wait_track();
        check(last_d, 32'd32);
        rd(`ADTC_OFF_RES_HI, 8'h02);
        rd(`ADTC_OFF_RES_LO, 8'hA5);
        rd(`ADTC_OFF_FLAGS, 8'h00);
        // automatic acquisition of four periods of two clocks; the go
        // and phase registers add two clocks ahead of the sampling
        wr(`ADTC_OFF_CTRL2, 8'h90);
        wait_track();
        wr(`ADTC_OFF_CTRL0, 8'h03);
        do begin @(posedge clk_i); acq_n++; end
        while (afe.convert !== 1'b1 && acq_n < 100);
        check(acq_n, 32'd10);
        wait_track();
        check(last_c, 32'd22);
        rd(`ADTC_OFF_RES_HI, 8'h01);
        rd(`ADTC_OFF_RES_LO, 8'h55);
        rd(`ADTC_OFF_FLAGS, 8'h40);
        check({30'h0, irqh, irql}, 32'h2);
        summarize();
    end
endmodule
